// ==== rtl/occ_pkg.sv ====
// constants, layouts and types of the oscillator control block
package occ_pkg;

    // ----------------------------------------------------------------
    // register map, byte addresses are four times the register index
    // ----------------------------------------------------------------
    localparam logic [11:0] OCC_CTRL_INDEX       = 12'hF86;
    localparam logic [15:0] OCC_CTRL_ADDR        = {2'h0, OCC_CTRL_INDEX, 2'h0};
    localparam logic [15:0] OCC_IRQ_STATUS_ADDR  = 16'h3E1C;
    localparam logic [15:0] OCC_IRQ_MASK_ADDR    = 16'h3E20;
    localparam logic [15:0] OCC_OPTION_ADDR      = 16'h3E24;

    // ----------------------------------------------------------------
    // control register contents
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       precision_osc_on;
        logic       crystal_osc_on;
        logic       watchdog_osc_on;
        logic       sysclk_fail_detect_on;
        logic       wdog_clk_fail_detect_on;
        logic [2:0] system_clock_source;
    } occ_ctrl_type;

    localparam logic [7:0] OCC_CTRL_RESET     = 8'hA0;
    localparam logic [7:0] OCC_UNLOCK_FIRST   = 8'hE7;
    localparam logic [7:0] OCC_UNLOCK_SECOND  = 8'h18;

    localparam logic [2:0] OCC_SRC_PRECISION_FAST = 3'h0;
    localparam logic [2:0] OCC_SRC_PRECISION_SLOW = 3'h1;
    localparam logic [2:0] OCC_SRC_CRYSTAL        = 3'h2;
    localparam logic [2:0] OCC_SRC_WATCHDOG       = 3'h3;
    localparam logic [2:0] OCC_SRC_EXTERNAL       = 3'h4;

    // ----------------------------------------------------------------
    // flash option inputs
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       crystal_off_at_reset_option;
        logic [1:0] crystal_drive_mode;
    } occ_option_type;

    // drive mode codes: 0 min, 1 medium, 2 max drive, 3 external rc
    localparam int unsigned OCC_MODE_W = 2;

    // ----------------------------------------------------------------
    // interrupt status and mask layout
    // ----------------------------------------------------------------
    localparam int unsigned OCC_IRQ_SYSCLK = 0;
    localparam int unsigned OCC_IRQ_WDOG   = 1;
    localparam int unsigned OCC_IRQ_W      = 2;

    // ----------------------------------------------------------------
    // timing and bus answers
    // ----------------------------------------------------------------
    localparam int unsigned OCC_WDOG_FAIL_CYCLES = 8004;
    localparam logic [1:0]  OCC_RESP_OKAY        = 2'h0;
    localparam logic [1:0]  OCC_RESP_SLVERR      = 2'h2;

    typedef enum logic [1:0] {
        OCC_LOCKED,
        OCC_HALF_OPEN,
        OCC_OPEN
    } occ_lock_type;

endpackage

// ==== rtl/occ_wdog_fail_detect.sv ====
// watchdog oscillator failure detector counting system clocks
`timescale 1ns/1ns
module occ_wdog_fail_detect
    import occ_pkg::*;
#(
    parameter int unsigned FAIL_CYCLES = OCC_WDOG_FAIL_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic wdog_edge,
    output logic      fail
);
    localparam int unsigned CNT_W = $clog2(FAIL_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(FAIL_CYCLES - 1);

    logic [CNT_W-1:0] count;
    logic             tripped;
    wire              restart = ~enable | wdog_edge;
    wire              at_last = (count == LAST) & ~tripped;

    // one pulse per failure; rearmed by a watchdog edge or a disable
    always_ff @(posedge clk_sys) begin
        if (rst | restart) begin
            count   <= '0;
            tripped <= 1'b0;
            fail    <= 1'b0;
        end else begin
            count   <= at_last ? '0 : (tripped ? count : count + 1'b1);
            tripped <= tripped | at_last;
            fail    <= at_last;
        end
    end

endmodule

// ==== rtl/occ_osc_control.sv ====
// oscillator control unit with locked control register on axi4-lite
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module occ_osc_control
    import occ_pkg::*;
#(
    parameter int unsigned ADDR_W      = 16,
    parameter int unsigned FAIL_CYCLES = OCC_WDOG_FAIL_CYCLES
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // flash options and analog side
    input  wire occ_option_type    flash_option,
    input  wire logic              wdog_osc_clk,
    input  wire logic              sysclk_fail_flag,
    // oscillator controls
    output logic                   irq,
    output logic                   precision_osc_on,
    output logic                   precision_osc_slow,
    output logic                   crystal_osc_on,
    output logic                   crystal_pins_to_osc,
    output logic                   watchdog_osc_on,
    output logic [2:0]             system_clock_source,
    output logic [OCC_MODE_W-1:0]  crystal_drive_mode,
    output logic                   sysclk_recovery_active
);

    // ----------------------------------------------------------------
    // decoding helper
    // ----------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [15:0]       offset);
        reg_hit = ({addr[ADDR_W-1:2], 2'h0} == ADDR_W'(offset));
    endfunction

    // ----------------------------------------------------------------
    // synchronisers for the analog inputs
    // ----------------------------------------------------------------
    logic wdog_meta;
    logic wdog_sync;
    logic wdog_last;
    logic sfail_meta;
    logic sfail_sync;
    logic sfail_last;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wdog_meta  <= 1'b0;
            wdog_sync  <= 1'b0;
            wdog_last  <= 1'b0;
            sfail_meta <= 1'b0;
            sfail_sync <= 1'b0;
            sfail_last <= 1'b0;
        end else begin
            wdog_meta  <= wdog_osc_clk;
            wdog_sync  <= wdog_meta;
            wdog_last  <= wdog_sync;
            sfail_meta <= sysclk_fail_flag;
            sfail_sync <= sfail_meta;
            sfail_last <= sfail_sync;
        end
    end

    wire wdog_edge  = wdog_sync & ~wdog_last;
    wire sfail_rise = sfail_sync & ~sfail_last;

    // ----------------------------------------------------------------
    // axi4-lite write and read channels
    // ----------------------------------------------------------------
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;

    wire aw_take    = s_axi_awvalid & s_axi_awready;
    wire w_take     = s_axi_wvalid & s_axi_wready;
    wire b_done     = s_axi_bvalid & s_axi_bready;
    wire ar_take    = s_axi_arvalid & s_axi_arready;
    wire r_done     = s_axi_rvalid & s_axi_rready;
    wire write_fire = aw_held & w_held & ~s_axi_bvalid;

    // address and data may arrive in either order
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr_q     <= '0;
            w_data_q      <= '0;
            w_strb_q      <= '0;
        end else begin
            if (aw_take) begin
                aw_addr_q     <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (write_fire) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
            if (b_done) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    wire hit_ctrl   = reg_hit(aw_addr_q, OCC_CTRL_ADDR);
    wire hit_status = reg_hit(aw_addr_q, OCC_IRQ_STATUS_ADDR);
    wire hit_mask   = reg_hit(aw_addr_q, OCC_IRQ_MASK_ADDR);
    wire hit_option = reg_hit(aw_addr_q, OCC_OPTION_ADDR);
    wire wr_mapped  = hit_ctrl | hit_status | hit_mask | hit_option;
    // only the low byte lane carries register bits
    wire lane0      = write_fire & w_strb_q[0];
    wire wr_ctrl    = lane0 & hit_ctrl;
    wire wr_status  = lane0 & hit_status;
    wire wr_mask    = lane0 & hit_mask;
    wire [7:0] wbyte = w_data_q[7:0];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= OCC_RESP_OKAY;
        end else if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? OCC_RESP_OKAY : OCC_RESP_SLVERR;
        end else if (b_done) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // unlock sequence
    // ----------------------------------------------------------------
    occ_lock_type lock;
    occ_lock_type next_lock;

    // only control writes move the sequence; reads never do
    always_comb begin
        next_lock = lock;
        case (lock)
            OCC_LOCKED: begin
                if (wr_ctrl && wbyte == OCC_UNLOCK_FIRST) begin
                    next_lock = OCC_HALF_OPEN;
                end
            end
            OCC_HALF_OPEN: begin
                if (wr_ctrl) begin
                    if (wbyte == OCC_UNLOCK_SECOND) begin
                        next_lock = OCC_OPEN;
                    end else if (wbyte == OCC_UNLOCK_FIRST) begin
                        next_lock = OCC_HALF_OPEN;
                    end else begin
                        next_lock = OCC_LOCKED;
                    end
                end
            end
            OCC_OPEN: begin
                if (wr_ctrl) begin
                    next_lock = OCC_LOCKED;
                end
            end
            default: begin
                next_lock = OCC_LOCKED;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lock <= OCC_LOCKED;
        end else begin
            lock <= next_lock;
        end
    end

    // ----------------------------------------------------------------
    // control register, source selection and recovery
    // ----------------------------------------------------------------
    occ_ctrl_type ctrl;
    logic [2:0]   eff_src;
    logic         crystal_keep;
    logic         wdog_failed;
    logic         recovering;
    logic         wdog_fail;

    wire apply         = wr_ctrl & (lock == OCC_OPEN);
    wire occ_ctrl_type next_ctrl = apply ? occ_ctrl_type'(wbyte) : ctrl;
    // reserved codes are stored but leave the running source alone
    wire src_valid     = wbyte[2:0] <= OCC_SRC_EXTERNAL;
    // recovery needs a live watchdog oscillator and no prior failure
    wire sfail_accept  = sfail_rise & ctrl.sysclk_fail_detect_on
                       & ctrl.watchdog_osc_on & ~wdog_failed
                       & (eff_src != OCC_SRC_WATCHDOG);
    wire [2:0] next_eff_src = sfail_accept ? OCC_SRC_WATCHDOG :
                              (apply & src_valid) ? wbyte[2:0] : eff_src;
    wire next_recovering = sfail_accept | (recovering & ~apply);
    wire next_keep       = crystal_keep & ~apply;
    wire next_xtal_on    = next_ctrl.crystal_osc_on | next_keep;
    // detector is blind when it would time itself
    wire wdog_det_on = ctrl.wdog_clk_fail_detect_on & ctrl.watchdog_osc_on
                     & (eff_src != OCC_SRC_WATCHDOG);

    occ_wdog_fail_detect #(
        .FAIL_CYCLES (FAIL_CYCLES)
    ) u_wdog_fail_detect (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .enable    (wdog_det_on),
        .wdog_edge (wdog_edge),
        .fail      (wdog_fail)
    );

    // reset holds the crystal as the option asks; flash is static
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl         <= occ_ctrl_type'(OCC_CTRL_RESET);
            eff_src      <= OCC_SRC_PRECISION_FAST;
            crystal_keep <= ~flash_option.crystal_off_at_reset_option;
            wdog_failed  <= 1'b0;
            recovering   <= 1'b0;
        end else begin
            ctrl         <= next_ctrl;
            eff_src      <= next_eff_src;
            crystal_keep <= next_keep;
            wdog_failed  <= wdog_failed | wdog_fail;
            recovering   <= next_recovering;
        end
    end

    // ----------------------------------------------------------------
    // oscillator outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            precision_osc_on       <= OCC_CTRL_RESET[7];
            watchdog_osc_on        <= OCC_CTRL_RESET[5];
            crystal_osc_on         <= ~flash_option.crystal_off_at_reset_option;
            crystal_pins_to_osc    <= ~flash_option.crystal_off_at_reset_option;
            precision_osc_slow     <= 1'b0;
            system_clock_source    <= OCC_SRC_PRECISION_FAST;
            crystal_drive_mode     <= '0;
            sysclk_recovery_active <= 1'b0;
        end else begin
            precision_osc_on       <= next_ctrl.precision_osc_on;
            watchdog_osc_on        <= next_ctrl.watchdog_osc_on;
            crystal_osc_on         <= next_xtal_on;
            crystal_pins_to_osc    <= next_xtal_on;
            precision_osc_slow     <= next_eff_src == OCC_SRC_PRECISION_SLOW;
            // select code goes to the clock mux; no divider follows it
            system_clock_source    <= next_eff_src;
            crystal_drive_mode     <= flash_option.crystal_drive_mode;
            sysclk_recovery_active <= next_recovering;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    logic [OCC_IRQ_W-1:0] irq_status;
    logic [OCC_IRQ_W-1:0] irq_mask;

    wire [OCC_IRQ_W-1:0] events   = {wdog_fail, sfail_accept};
    wire [OCC_IRQ_W-1:0] clr_bits = wr_status ? wbyte[OCC_IRQ_W-1:0] : '0;
    // a new event wins over a clear in the same cycle
    wire [OCC_IRQ_W-1:0] next_status = (irq_status & ~clr_bits) | events;
    wire [OCC_IRQ_W-1:0] next_mask   = wr_mask ? wbyte[OCC_IRQ_W-1:0]
                                               : irq_mask;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_status <= '0;
            irq_mask   <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_status;
            irq_mask   <= next_mask;
            irq        <= |(next_status & next_mask);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    wire rd_ctrl   = reg_hit(s_axi_araddr, OCC_CTRL_ADDR);
    wire rd_status = reg_hit(s_axi_araddr, OCC_IRQ_STATUS_ADDR);
    wire rd_mask   = reg_hit(s_axi_araddr, OCC_IRQ_MASK_ADDR);
    wire rd_option = reg_hit(s_axi_araddr, OCC_OPTION_ADDR);
    wire rd_mapped = rd_ctrl | rd_status | rd_mask | rd_option;

    wire [31:0] option_word = {22'h0, lock == OCC_HALF_OPEN, lock == OCC_OPEN,
                               crystal_keep,
                               flash_option.crystal_off_at_reset_option,
                               flash_option.crystal_drive_mode,
                               wdog_failed, eff_src};
    wire [31:0] rd_word = rd_ctrl   ? {24'h0, ctrl} :
                          rd_status ? {30'h0, irq_status} :
                          rd_mask   ? {30'h0, irq_mask} :
                          rd_option ? option_word : 32'h0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= OCC_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_mapped ? OCC_RESP_OKAY : OCC_RESP_SLVERR;
        end else if (r_done) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

endmodule

// ==== testbench/occ_osc_control_sva.sv ====
// checker on the ports of the oscillator control block
`timescale 1ns/1ns
module occ_osc_control_sva
    import occ_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire occ_option_type        flash_option,
    input wire logic                  precision_osc_on,
    input wire logic                  precision_osc_slow,
    input wire logic                  crystal_osc_on,
    input wire logic                  crystal_pins_to_osc,
    input wire logic                  watchdog_osc_on,
    input wire logic [2:0]            system_clock_source,
    input wire logic [OCC_MODE_W-1:0] crystal_drive_mode
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_reset_val;
        $past(rst) |-> precision_osc_on && watchdog_osc_on
            && !precision_osc_slow && system_clock_source == 3'h0;
    endproperty
    a_reset_val: assert property (p_reset_val)
        else $error("oscillator enables wrong after reset");
    property p_pins;
        crystal_pins_to_osc == crystal_osc_on;
    endproperty
    a_pins: assert property (p_pins)
        else $error("crystal pins not following crystal enable");
    property p_src;
        system_clock_source <= 3'h4
            && precision_osc_slow == (system_clock_source == 3'h1);
    endproperty
    a_src: assert property (p_src)
        else $error("running clock source illegal");
    property p_mode;
        !$past(rst) |->
            crystal_drive_mode == $past(flash_option.crystal_drive_mode);
    endproperty
    a_mode: assert property (p_mode)
        else $error("drive mode not copied from option");
    // enables move only with an applied write, answered in that cycle
    property p_ctl_chg;
        $changed({precision_osc_on, crystal_osc_on, watchdog_osc_on})
            |-> s_axi_bvalid;
    endproperty
    a_ctl_chg: assert property (p_ctl_chg)
        else $error("enable changed without a write");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    property p_r_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_ans: assert property (p_r_ans)
        else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data not held");

    c_slow: cover property (precision_osc_slow);
    c_ext: cover property (system_clock_source == OCC_SRC_EXTERNAL);
    c_rstall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind occ_osc_control occ_osc_control_sva occ_osc_control_sva_inst (.*);

// ==== testbench/occ_osc_control_tb_top.sv ====
// self-checking bench for the oscillator control block
`timescale 1ns/1ns
module occ_osc_control_tb_top
    import occ_pkg::*;
;
    localparam logic [15:0] CTL = OCC_CTRL_ADDR;
    localparam logic [15:0] STS = OCC_IRQ_STATUS_ADDR;
    localparam logic [15:0] MSK = OCC_IRQ_MASK_ADDR;
    logic           clk_sys = 1'b0;
    logic           rst = 1'b1;
    logic [15:0]    s_axi_awaddr, s_axi_araddr;
    logic [31:0]    s_axi_wdata, s_axi_rdata;
    logic [3:0]     s_axi_wstrb = 4'h1;
    logic [1:0]     s_axi_bresp, s_axi_rresp, crystal_drive_mode;
    logic [2:0]     system_clock_source, m_src;
    logic [7:0]     m_ctrl;
    logic           s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic           s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic           s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic           s_axi_rready, wdog_osc_clk, sysclk_fail_flag, irq;
    logic           precision_osc_on, precision_osc_slow, crystal_osc_on;
    logic           crystal_pins_to_osc, watchdog_osc_on, wdog_run, m_keep;
    logic           sysclk_recovery_active;
    occ_option_type flash_option;
    int             n_errors = 0;
    int             tests_run = 0;
    int             m_lock, seed;

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (wdog_run) wdog_osc_clk <= ~wdog_osc_clk;

    occ_osc_control #(.FAIL_CYCLES(20)) occ_osc_control_inst (.*);

    // ------
    // tasks
    // ------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic mreset;
        m_ctrl = OCC_CTRL_RESET;
        m_lock = 0;
        m_src = 3'h0;
        m_keep = !flash_option.crystal_off_at_reset_option;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (!s_axi_bready) s_axi_bready <= 1'($random(seed));
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp},
            {30'h0, (a inside {CTL, STS, MSK, OCC_OPTION_ADDR}) ?
                    OCC_RESP_OKAY : OCC_RESP_SLVERR});
        if (a == CTL) begin
            if (m_lock == 2) begin
                m_ctrl = d;
                m_keep = 1'b0;
                if (d[2:0] <= 3'h4) m_src = d[2:0];
            end
            if (m_lock == 1 && d == OCC_UNLOCK_SECOND) m_lock = 2;
            else m_lock = (m_lock != 2 && d == OCC_UNLOCK_FIRST) ? 1 : 0;
        end
    endtask
    task automatic rchk(input logic [15:0] a, input logic [31:0] e,
                        input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (!s_axi_rready) s_axi_rready <= 1'($random(seed));
        end while (!(s_axi_rvalid && s_axi_rready));
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
    endtask
    task automatic sync;
        rchk(CTL, {24'h0, m_ctrl}, OCC_RESP_OKAY);
        chk({24'h0, precision_osc_on, crystal_osc_on, crystal_pins_to_osc,
             watchdog_osc_on, precision_osc_slow, system_clock_source},
            {24'h0, m_ctrl[7], m_ctrl[6] | m_keep, m_ctrl[6] | m_keep,
             m_ctrl[5], m_src == 3'h1, m_src});
    endtask
    task automatic unl(input logic [7:0] v);
        wr(CTL, OCC_UNLOCK_FIRST);
        wr(CTL, OCC_UNLOCK_SECOND);
        wr(CTL, v);
    endtask

    // ------
    // sequence
    // ------
    initial begin
        int k;
        logic [7:0] v;
        seed = 60900;
        flash_option = 3'($random(seed));
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready, wdog_osc_clk, sysclk_fail_flag} = '0;
        wdog_run = 1'b1;
        mreset;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        sync;
        chk(crystal_drive_mode, flash_option.crystal_drive_mode);
        $display("reset test done");
        for (int c = 0; c < 8; c++) begin
            // crystal is switched on one pass before it is selected
            if (c == 2) repeat (1000) @(posedge clk_sys);
            unl({1'b1, (c != 0), 3'h4, 3'(c)});
            sync;
        end
        $display("select test done");
        unl(8'hA0);
        unl(8'hB0);
        wr(MSK, 8'h01);
        sysclk_fail_flag <= 1'b1;
        repeat (8) @(posedge clk_sys);
        m_src = OCC_SRC_WATCHDOG;
        chk({30'h0, sysclk_recovery_active, irq}, 32'h3);
        rchk(STS, 32'h1, OCC_RESP_OKAY);
        sysclk_fail_flag <= 1'b0;
        wr(STS, 8'h01);
        unl(8'hA3);
        unl(8'hA0);
        sync;
        chk({30'h0, sysclk_recovery_active, irq}, 32'h0);
        $display("recovery test done");
        wr(MSK, 8'h00);
        unl(8'hA8);
        repeat (40) @(posedge clk_sys);
        rchk(STS, 32'h0, OCC_RESP_OKAY);
        wdog_run <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rchk(STS, 32'h0, OCC_RESP_OKAY);
        repeat (20) @(posedge clk_sys);
        rchk(STS, 32'h2, OCC_RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wr(MSK, 8'h02);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        unl(8'hA0);
        wr(STS, 8'h02);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        rchk(16'h0100, 32'h0, OCC_RESP_SLVERR);
        $display("watchdog test done");
        // random orders of unlock values, stray writes and reads between
        for (int i = 0; i < 30; i++) begin
            k = $random(seed) & 3;
            v = 8'($random(seed)) & 8'hE7;
            // a fresh crystal is never selected in the same write
            if (v[2:0] == OCC_SRC_CRYSTAL) v[0] = 1'b1;
            if (k == 0) v = OCC_UNLOCK_FIRST;
            if (k == 1) v = OCC_UNLOCK_SECOND;
            wr((i % 5 == 4) ? 16'h0100 : CTL, v);
            sync;
        end
        $display("order test done");
        rst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        mreset;
        sync;
        $display("second reset test done");
        test_done;
    end

    initial begin
        #100000;
        n_errors++;
        test_done;
    end
endmodule
